// *** include/csw_pkg.sv ***
/*
 * Shared constants for the clock select and warm-up control block:
 * register offsets, field positions, reset values, gear and prescaler codes, timing.
 * Assumes a 200 MHz ref_clk and a 32-bit Avalon-MM register port with byte addresses.
 */
package csw_pkg;

	// Register byte offsets
	localparam logic [4:0] OFS_SYS_CTRL = 5'h00;
	localparam logic [4:0] OFS_OSC_CTRL = 5'h04;
	localparam logic [4:0] OFS_EXT_SEL  = 5'h0c;
	localparam logic [4:0] OFS_SYS_SEL  = 5'h10;

	// System control register fields
	localparam int GEAR_LSB     = 0;
	localparam int PRESC_LSB    = 8;
	localparam int PER_SRC_BIT  = 12;

	// Oscillator control register fields
	localparam int WARM_START_BIT = 0;
	localparam int WARM_FLAG_BIT  = 1;
	localparam int WARM_SPD_BIT   = 3;
	localparam int EXT_OSC_RUN_BIT = 8;
	localparam int LS_OSC_EN_BIT  = 9;
	localparam int LS_SRC_BIT     = 10;
	localparam int EXT_IN_EN_BIT  = 11;
	localparam int WARM_LO_LSB    = 14;
	localparam int INT_OSC_EN_BIT = 16;
	localparam int HS_OSC_SEL_BIT = 17;
	localparam int EXT_OSC_USE_BIT = 18;
	localparam int WARM_HS_BIT    = 19;
	localparam int WARM_HI_LSB    = 20;

	// System clock select register fields
	localparam int SYS_FLAG_BIT = 0;
	localparam int SYS_SEL_BIT  = 1;

	// Reset values
	localparam logic [2:0]  GEAR_RST       = 3'h0;
	localparam logic [2:0]  PRESC_RST      = 3'h0;
	localparam logic [11:0] WARM_HI_RST    = 12'h800;
	localparam logic [1:0]  WARM_LO_RST    = 2'h0;
	localparam logic        INT_OSC_EN_RST = 1'h1;
	localparam logic [3:0]  OSC_FIXED      = 4'h3;
	localparam logic [31:0] EXT_SEL_FIXED  = 32'h0000721e;

	// Gear and prescaler codes
	localparam logic [2:0] GEAR_DIV1  = 3'h0;
	localparam logic [2:0] GEAR_DIV2  = 3'h4;
	localparam logic [2:0] GEAR_DIV4  = 3'h5;
	localparam logic [2:0] GEAR_DIV8  = 3'h6;
	localparam logic [2:0] GEAR_DIV16 = 3'h7;
	localparam logic [2:0] PRESC_MAX  = 3'h5;

	// Gear switch-over delay
	localparam int         REF_CLK_PS    = 5000;
	localparam int         GEAR_APPLY_NS = 20;
	localparam logic [2:0] GEAR_APPLY_CYC = 3'((GEAR_APPLY_NS * 1000 + REF_CLK_PS - 1) / REF_CLK_PS);

	// Warm-up timer states
	typedef enum logic [0:0] {
		WARM_IDLE  = 1'b0,
		WARM_COUNT = 1'b1
	} csw_warm_state_t;

endpackage

// *** core/csw_tick_div.sv ***
/*
 * Power-of-two tick divider: passes one of every 2**ratio_log2 input ticks.
 * Assumes tick_in is a one-cycle pulse on ref_clk; ratio_log2 at most 5.
 */
`timescale 1ns/1ps
module csw_tick_div (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Ticks
	input  wire logic       tick_in,
	input  wire logic [2:0] ratio_log2,
	output logic            tick_out
);
	logic [4:0] cnt_q;
	logic [2:0] ratio_q;
	wire  [4:0] mask = 5'((6'h01 << ratio_log2) - 6'h01);
	wire        wrap = (cnt_q & mask) == mask;

	// Ratio change restarts the count so no short first period leaks out
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q    <= 5'h00;
			ratio_q  <= 3'h0;
			tick_out <= 1'b0;
		end
		else
		begin
			ratio_q  <= ratio_log2;
			tick_out <= tick_in && wrap && ratio_q == ratio_log2;
			if (ratio_q != ratio_log2 || (tick_in && wrap))
				cnt_q <= 5'h00;
			else if (tick_in)
				cnt_q <= cnt_q + 5'h01;
		end
	end

	div_rate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		tick_out |-> $past(tick_in) && $past(wrap))
		else $error("divider ticked off its boundary");
endmodule

// *** core/csw_warm_timer.sv ***
/*
 * Warm-up counter: clears on start, counts source ticks, stops at the target.
 * Assumes start and src_tick are one-cycle pulses on ref_clk.
 */
`timescale 1ns/1ps
module csw_warm_timer (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Control
	input  wire logic        start,
	input  wire logic        src_tick,
	input  wire logic [15:0] target,
	// Status
	output logic             active
);
	csw_pkg::csw_warm_state_t state_q;
	logic [15:0]              cnt_q;
	wire                      hit = cnt_q == target;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= csw_pkg::WARM_IDLE;
			cnt_q   <= 16'h0000;
		end
		else if (start)
		begin
			state_q <= csw_pkg::WARM_COUNT;
			cnt_q   <= 16'h0000;
		end
		else
		begin
			case (state_q)
				csw_pkg::WARM_COUNT:
				begin
					if (hit)
						state_q <= csw_pkg::WARM_IDLE;
					else if (src_tick)
						cnt_q <= cnt_q + 16'h0001;
				end
				default:
					state_q <= csw_pkg::WARM_IDLE;
			endcase
		end
	end

	assign active = state_q == csw_pkg::WARM_COUNT;

	warm_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		start |=> active && cnt_q == 16'h0000)
		else $error("warm-up did not clear on start");
	warm_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		active && hit && !start |=> !active && $stable(cnt_q))
		else $error("warm-up did not end at target");
endmodule

// *** core/csw_top.sv ***
/*
 * Clock select and warm-up control: source selectors, gear and prescaler dividers,
 * system clock switch, warm-up timer and the Avalon-MM register slave.
 * Oscillator and clock pins arrive asynchronously and are sampled on ref_clk;
 * derived clocks leave as one-cycle ticks on ref_clk. lp_wake is a same-domain pulse.
 */
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - Clock tree built as chain of selectors
// - System clock: 0 high-speed, 1 low-speed
// - Status bit shows clock actually driving system
// - Gear 1..16, prescaler 1..32 division ratios
// - Reset: internal on, external off, gear undivided
// - After reset all clocks equal internal oscillator
// - Wake starts warm-up; system clock held meanwhile
// - Two bits choose warm-up count source
// - High-speed source ignores lower target field
// - Start bit begins count; flag shows counting
// - System source: internal, external high, low
// - Gear change applied after short delay
// - No direct crystal to clock input switch
// - Gear codes 000,100..111; others reserved
// - Prescaler codes 000..101; others reserved
module csw_top (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Avalon-MM register slave
	input  wire logic [4:0]  avm_address,
	input  wire logic        avm_read,
	input  wire logic        avm_write,
	input  wire logic [31:0] avm_writedata,
	input  wire logic [3:0]  avm_byteenable,
	output logic [31:0]      avm_readdata,
	output logic             avm_waitrequest,
	// Oscillator and clock pins
	input  wire logic        int_hs_osc_clk,
	input  wire logic        ext_hs_crystal_clk,
	input  wire logic        ext_hs_input_clk,
	input  wire logic        ext_ls_osc_clk,
	input  wire logic        ext_ls_input_clk,
	// Wake from standby
	input  wire logic        lp_wake,
	// Oscillator controls
	output logic             int_osc_enable,
	output logic             ext_hs_osc_en,
	output logic             ext_in_en,
	output logic             ls_osc_en,
	output logic             pll_en,
	// Derived clock ticks and system clock hold
	output logic             fc_tick,
	output logic             sys_clk_tick,
	output logic             periph_tick,
	output logic             prescaler_tick,
	output logic             cpu_clk_hold
);
	localparam int NPIN = 5;

	function automatic logic gear_legal(input logic [2:0] code);
		gear_legal = code == csw_pkg::GEAR_DIV1 || code[2];
	endfunction

	function automatic logic [2:0] gear_log2(input logic [2:0] code);
		gear_log2 = code[2] ? 3'(code[1:0]) + 3'h1 : 3'h0;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] m;
		m     = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		merge = (cur & ~m) | (wd & m);
	endfunction

	// Pin sampling
	wire  [NPIN-1:0] pin_raw = {ext_ls_input_clk, ext_ls_osc_clk, ext_hs_input_clk,
	                            ext_hs_crystal_clk, int_hs_osc_clk};
	logic [NPIN-1:0] pin_s1_q;
	logic [NPIN-1:0] pin_s2_q;
	logic [NPIN-1:0] pin_s3_q;
	logic [NPIN-1:0] pin_rise;

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++)
		begin : g_pin
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					pin_s1_q[gi] <= 1'b0;
					pin_s2_q[gi] <= 1'b0;
					pin_s3_q[gi] <= 1'b0;
				end
				else
				begin
					pin_s1_q[gi] <= pin_raw[gi];
					pin_s2_q[gi] <= pin_s1_q[gi];
					pin_s3_q[gi] <= pin_s2_q[gi];
				end
			end
			assign pin_rise[gi] = pin_s2_q[gi] & ~pin_s3_q[gi];
		end
	endgenerate

	// Registers
	logic [2:0]  gear_q;
	logic [2:0]  gear_eff_q;
	logic [2:0]  gear_dly_q;
	logic [2:0]  prescale_div_q;
	logic        periph_src_sel_q;
	logic [11:0] warm_target_hi_q;
	logic [1:0]  warm_target_lo_q;
	logic        warm_src_hs_sel_q;
	logic        warm_src_speed_sel_q;
	logic        ext_osc_use_q;
	logic        hs_osc_sel_q;
	logic        ext_clk_input_sel_q;
	logic        ls_src_sel_q;
	logic        sys_clk_src_sel_q;
	logic        sys_clk_src_flag_q;
	logic        warm_active;

	wire [31:0] sys_ctrl_word = {19'h0, periph_src_sel_q, 1'b0, prescale_div_q, 5'h00, gear_q};
	wire [31:0] osc_word = {warm_target_hi_q, warm_src_hs_sel_q, ext_osc_use_q, hs_osc_sel_q,
	                        int_osc_enable, warm_target_lo_q, 2'h0, ext_in_en, ls_src_sel_q,
	                        ls_osc_en, ext_hs_osc_en, csw_pkg::OSC_FIXED, warm_src_speed_sel_q,
	                        1'b0, warm_active, 1'b0};
	wire [31:0] ext_word = csw_pkg::EXT_SEL_FIXED | {31'h0, ext_clk_input_sel_q};
	wire [31:0] sys_sel_word = {30'h0, sys_clk_src_sel_q, sys_clk_src_flag_q};

	// Bus decode: one wait state, write and read data at the waitrequest-low edge
	wire        bus_req = avm_read | avm_write;
	wire        wr_go   = avm_write & ~avm_waitrequest;
	wire        sel_sys = avm_address == csw_pkg::OFS_SYS_CTRL;
	wire        sel_osc = avm_address == csw_pkg::OFS_OSC_CTRL;
	wire        sel_ext = avm_address == csw_pkg::OFS_EXT_SEL;
	wire        sel_ss  = avm_address == csw_pkg::OFS_SYS_SEL;
	wire [31:0] rd_mux  = sel_sys ? sys_ctrl_word : sel_osc ? osc_word :
	                      sel_ext ? ext_word : sel_ss ? sys_sel_word : 32'h0;
	wire [31:0] m_sys = merge(sys_ctrl_word, avm_writedata, avm_byteenable);
	wire [31:0] m_osc = merge(osc_word, avm_writedata, avm_byteenable);
	wire [31:0] m_ext = merge(ext_word, avm_writedata, avm_byteenable);
	wire [31:0] m_ss  = merge(sys_sel_word, avm_writedata, avm_byteenable);
	wire        wr_sys = wr_go & sel_sys;
	wire        wr_osc = wr_go & sel_osc;
	wire        wr_ext = wr_go & sel_ext;
	wire        wr_ss  = wr_go & sel_ss;
	wire [2:0]  new_gear  = m_sys[csw_pkg::GEAR_LSB +: 3];
	wire [2:0]  new_presc = m_sys[csw_pkg::PRESC_LSB +: 3];
	wire        gear_wr   = wr_sys & gear_legal(new_gear);
	wire        presc_wr  = wr_sys & (new_presc <= csw_pkg::PRESC_MAX);
	wire        ext_sel_ok = ~hs_osc_sel_q;
	wire        ls_sel_ok  = ~sys_clk_src_flag_q & ~sys_clk_src_sel_q;
	wire        sw_start   = wr_osc & m_osc[csw_pkg::WARM_START_BIT];

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			avm_waitrequest <= 1'b1;
			avm_readdata    <= 32'h0;
		end
		else
		begin
			avm_waitrequest <= ~(avm_waitrequest & bus_req);
			avm_readdata    <= (avm_waitrequest & avm_read) ? rd_mux : avm_readdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gear_q         <= csw_pkg::GEAR_RST;
			prescale_div_q <= csw_pkg::PRESC_RST;
			periph_src_sel_q <= 1'b0;
		end
		else if (wr_sys)
		begin
			if (gear_legal(new_gear))
				gear_q <= new_gear;
			if (new_presc <= csw_pkg::PRESC_MAX)
				prescale_div_q <= new_presc;
			periph_src_sel_q <= m_sys[csw_pkg::PER_SRC_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			warm_target_hi_q     <= csw_pkg::WARM_HI_RST;
			warm_target_lo_q     <= csw_pkg::WARM_LO_RST;
			warm_src_hs_sel_q    <= 1'b0;
			warm_src_speed_sel_q <= 1'b0;
			ext_osc_use_q        <= 1'b0;
			hs_osc_sel_q         <= 1'b0;
			int_osc_enable       <= csw_pkg::INT_OSC_EN_RST;
			ext_hs_osc_en        <= 1'b0;
			ext_in_en            <= 1'b0;
			ls_osc_en            <= 1'b0;
			ls_src_sel_q         <= 1'b0;
		end
		else if (wr_osc)
		begin
			warm_target_hi_q     <= m_osc[csw_pkg::WARM_HI_LSB +: 12];
			warm_target_lo_q     <= m_osc[csw_pkg::WARM_LO_LSB +: 2];
			warm_src_hs_sel_q    <= m_osc[csw_pkg::WARM_HS_BIT];
			warm_src_speed_sel_q <= m_osc[csw_pkg::WARM_SPD_BIT];
			ext_osc_use_q        <= m_osc[csw_pkg::EXT_OSC_USE_BIT];
			hs_osc_sel_q         <= m_osc[csw_pkg::HS_OSC_SEL_BIT];
			int_osc_enable       <= m_osc[csw_pkg::INT_OSC_EN_BIT];
			ext_hs_osc_en        <= m_osc[csw_pkg::EXT_OSC_RUN_BIT];
			ext_in_en            <= m_osc[csw_pkg::EXT_IN_EN_BIT];
			ls_osc_en            <= m_osc[csw_pkg::LS_OSC_EN_BIT];
			if (ls_sel_ok)
				ls_src_sel_q <= m_osc[csw_pkg::LS_SRC_BIT];
		end
	end

	// Select bits; status flag is hardware-owned and ignores writes
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_clk_input_sel_q <= 1'b0;
			sys_clk_src_sel_q   <= 1'b0;
			pll_en              <= 1'b0;
		end
		else
		begin
			if (wr_ext && ext_sel_ok)
				ext_clk_input_sel_q <= m_ext[0];
			if (wr_ss)
				sys_clk_src_sel_q <= m_ss[csw_pkg::SYS_SEL_BIT];
		end
	end

	// Clock tree selectors
	wire int_tick   = pin_rise[0] & int_osc_enable;
	wire xtal_tick  = pin_rise[1] & ext_hs_osc_en;
	wire hs_in_tick = pin_rise[2] & ext_in_en;
	wire ls_tick    = ls_src_sel_q ? pin_rise[4] : (pin_rise[3] & ls_osc_en);
	wire osc_tick   = hs_osc_sel_q ? xtal_tick : int_tick;
	wire fc_src     = ext_clk_input_sel_q ? hs_in_tick : osc_tick;
	wire fgear_tick;
	wire presc_tick;
	wire sys_src    = sys_clk_src_flag_q ? ls_tick : fgear_tick;
	wire per_src    = periph_src_sel_q ? fc_src : fgear_tick;
	wire sw_target  = sys_clk_src_sel_q ? ls_tick : fc_src;

	// Gear change waits out a short delay before reaching the divider
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gear_eff_q <= csw_pkg::GEAR_RST;
			gear_dly_q <= 3'h0;
		end
		else if (gear_eff_q != gear_q && gear_dly_q != csw_pkg::GEAR_APPLY_CYC)
			gear_dly_q <= gear_dly_q + 3'h1;
		else
		begin
			gear_eff_q <= gear_q;
			gear_dly_q <= 3'h0;
		end
	end

	csw_tick_div u_gear (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.tick_in    (fc_src),
		.ratio_log2 (gear_log2(gear_eff_q)),
		.tick_out   (fgear_tick)
	);

	csw_tick_div u_presc (
		.ref_clk    (ref_clk),
		.rst_n      (rst_n),
		.tick_in    (per_src),
		.ratio_log2 (prescale_div_q),
		.tick_out   (presc_tick)
	);

	// Warm-up source and target; lower field unused for a high-speed source
	wire        warm_tick   = warm_src_speed_sel_q ? ls_tick :
	                          (warm_src_hs_sel_q ? xtal_tick : int_tick);
	wire [1:0]  warm_lo_eff = warm_src_speed_sel_q ? warm_target_lo_q : 2'h0;
	wire [15:0] warm_target = {warm_target_hi_q, warm_lo_eff, 2'h0};
	wire        warm_go     = sw_start | lp_wake;

	csw_warm_timer u_warm (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.start    (warm_go),
		.src_tick (warm_tick),
		.target   (warm_target),
		.active   (warm_active)
	);

	// Switch lands on an edge of the new source so the flag tracks the real clock
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sys_clk_src_flag_q <= 1'b0;
			cpu_clk_hold       <= 1'b0;
			fc_tick            <= 1'b0;
			sys_clk_tick       <= 1'b0;
			periph_tick        <= 1'b0;
			prescaler_tick     <= 1'b0;
		end
		else
		begin
			if (sys_clk_src_flag_q != sys_clk_src_sel_q && sw_target)
				sys_clk_src_flag_q <= sys_clk_src_sel_q;
			cpu_clk_hold   <= lp_wake | (cpu_clk_hold & warm_active);
			fc_tick        <= fc_src;
			sys_clk_tick   <= sys_src & ~cpu_clk_hold & ~lp_wake;
			periph_tick    <= per_src;
			prescaler_tick <= presc_tick;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_gear_write;
		gear_wr && new_gear != gear_eff_q;
	endsequence

	gear_late_a: assert property (s_gear_write |=> !wr_sys [*1] ##0 (gear_eff_q != gear_q) ##[1:6] (gear_eff_q == gear_q))
		else $error("gear change not applied after delay");
	gear_code_a: assert property (gear_legal(gear_q) && gear_legal(gear_eff_q))
		else $error("reserved gear code stored");
	presc_code_a: assert property (prescale_div_q <= csw_pkg::PRESC_MAX)
		else $error("reserved prescaler code stored");
	sys_hs_a: assert property (!sys_clk_src_flag_q && fgear_tick && !cpu_clk_hold && !lp_wake |=> sys_clk_tick)
		else $error("high-speed tick not passed to system clock");
	flag_move_a: assert property ($changed(sys_clk_src_flag_q) |-> $past(sw_target) &&
		sys_clk_src_flag_q == $past(sys_clk_src_sel_q))
		else $error("status flag moved without a source edge");
	wake_hold_a: assert property (lp_wake |=> cpu_clk_hold && warm_active ##0 (!sys_clk_tick [*1]))
		else $error("wake did not hold system clock");
	hold_release_a: assert property (cpu_clk_hold && !warm_active && !lp_wake |=> !cpu_clk_hold)
		else $error("system clock held after warm-up end");
	start_flag_a: assert property (sw_start |=> warm_active ##1 (osc_word[csw_pkg::WARM_FLAG_BIT]))
		else $error("start write did not raise warm-up flag");
	no_direct_a: assert property (wr_ext && hs_osc_sel_q |=> $stable(ext_clk_input_sel_q))
		else $error("direct crystal to input switch taken");
	warm_lo_a: assert property (!warm_src_speed_sel_q |-> warm_target[3:0] == 4'h0)
		else $error("lower field used for high-speed warm-up");
	bus_ack_a: assert property (!avm_waitrequest |=> avm_waitrequest)
		else $error("waitrequest low for more than one cycle");
endmodule

// *** verif/csw_osc_model.sv ***
/*
 * Behavioural oscillators and clock pins at the far side of the clock block.
 * Assumes the bench ties the block's oscillator enables to the enable inputs.
 */
`timescale 1ns/1ps
module csw_osc_model #(
	parameter int INT_HALF = 11,
	parameter int XT_HALF  = 13,
	parameter int IN_HALF  = 17,
	parameter int LS_HALF  = 60
) (
	// Oscillator enables
	input  wire logic int_en,
	input  wire logic xt_en,
	input  wire logic ls_en,
	// Clock pins
	output logic      int_clk,
	output logic      xt_clk,
	output logic      in_clk,
	output logic      ls_clk,
	output logic      ls_in_clk
);
	initial
	begin
		int_clk = 1'b0;
		xt_clk = 1'b0;
		in_clk = 1'b0;
		ls_clk = 1'b0;
		ls_in_clk = 1'b0;
	end
	// Stopped oscillators sit low; driven input pins run free
	always #(INT_HALF) int_clk = int_en & ~int_clk;
	always #(XT_HALF) xt_clk = xt_en & ~xt_clk;
	always #(IN_HALF) in_clk = ~in_clk;
	always #(LS_HALF) ls_clk = ls_en & ~ls_clk;
	always #(LS_HALF + 7) ls_in_clk = ~ls_in_clk;
endmodule

// *** verif/csw_top_test.sv ***
/*
 * Self-checking bench for the clock select and warm-up block, with a register model.
 * Assumes the oscillator model on the pins and the design's assertions in place.
 */
`timescale 1ns/1ps
`define CHK(g, e) \
	begin n_compared++; if ((g) !== (e)) \
	begin err_total++; $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module csw_top_test;
	logic        ref_clk, rst_n, avm_read, avm_write, avm_waitrequest, lp_wake;
	logic [4:0]  avm_address;
	logic [31:0] avm_writedata, avm_readdata, rd, m_sys, m_osc, lfsr_q;
	logic [3:0]  avm_byteenable;
	logic        int_hs_osc_clk, ext_hs_crystal_clk, ext_hs_input_clk, ext_ls_osc_clk, ext_ls_input_clk;
	logic        int_osc_enable, ext_hs_osc_en, ext_in_en, ls_osc_en, pll_en;
	logic        fc_tick, sys_clk_tick, periph_tick, prescaler_tick, cpu_clk_hold;
	int          err_total, n_compared, c_fc, c_sys, c_per, c_pre, c_ls, hold_bad;
	int          d_sys, d_per, d_pre, s, i, n;

	csw_top i_dut (.ref_clk, .rst_n, .avm_address, .avm_read, .avm_write, .avm_writedata,
		.avm_byteenable, .avm_readdata, .avm_waitrequest, .int_hs_osc_clk, .ext_hs_crystal_clk,
		.ext_hs_input_clk, .ext_ls_osc_clk, .ext_ls_input_clk, .lp_wake, .int_osc_enable,
		.ext_hs_osc_en, .ext_in_en, .ls_osc_en, .pll_en, .fc_tick, .sys_clk_tick, .periph_tick,
		.prescaler_tick, .cpu_clk_hold);
	csw_osc_model i_osc (.int_en(int_osc_enable), .xt_en(ext_hs_osc_en), .ls_en(ls_osc_en),
		.int_clk(int_hs_osc_clk), .xt_clk(ext_hs_crystal_clk), .in_clk(ext_hs_input_clk),
		.ls_clk(ext_ls_osc_clk), .ls_in_clk(ext_ls_input_clk));

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		c_fc <= c_fc + int'(fc_tick === 1'b1);
		c_sys <= c_sys + int'(sys_clk_tick === 1'b1);
		c_per <= c_per + int'(periph_tick === 1'b1);
		c_pre <= c_pre + int'(prescaler_tick === 1'b1);
		hold_bad <= hold_bad + int'(cpu_clk_hold === 1'b1 && sys_clk_tick === 1'b1);
	end
	always @(posedge ext_ls_osc_clk) c_ls <= c_ls + 1;

	function logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function logic inr(input int v, input int lo, input int hi);
		return v >= lo && v <= hi;
	endfunction
	// Start bit reads 0, bits 7:4 read 0011, flag is live
	function logic [31:0] osc_exp(input logic flag);
		return (m_osc & 32'hffffcf08) | 32'h30 | {30'h0, flag, 1'b0};
	endfunction

	task stop_test;
		if (err_total == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task tmo(input int cnt, input int lim);
		if (cnt >= lim)
		begin
			err_total++;
			stop_test();
		end
	endtask
	// Request held until waitrequest is sampled low at a rising edge
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
		int k;
		@(posedge ref_clk);
		avm_read <= ~wr;
		avm_write <= wr;
		avm_address <= a;
		avm_writedata <= d;
		avm_byteenable <= be;
		k = 0;
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (avm_waitrequest !== 1'b0 && k < 40);
		rd = avm_readdata;
		avm_read <= 1'b0;
		avm_write <= 1'b0;
		tmo(k, 40);
	endtask
	task rchk(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hf);
		`CHK(rd, e)
	endtask
	task poll(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] v);
		int k;
		k = 0;
		do
		begin
			bus(1'b0, a, 32'h0, 4'hf);
			k++;
		end
		while ((rd & mask) !== v && k < 500);
		tmo(k, 500);
	endtask
	task wosc(input logic [31:0] d);
		m_osc = d;
		bus(1'b1, csw_pkg::OFS_OSC_CTRL, d, 4'hf);
	endtask
	// Reserved gear and prescaler codes leave their field alone
	task wsys(input logic [31:0] d, input logic [3:0] be);
		if (be[0] && (d[2:0] == 3'h0 || d[2]))
			m_sys[2:0] = d[2:0];
		if (be[1] && d[10:8] <= 3'h5)
			m_sys[10:8] = d[10:8];
		if (be[1])
			m_sys[12] = d[12];
		bus(1'b1, csw_pkg::OFS_SYS_CTRL, d, be);
	endtask
	task meas;
		int k, s0, s1, s2, s3;
		s0 = c_fc;
		s1 = c_sys;
		s2 = c_per;
		s3 = c_pre;
		k = 0;
		while (c_fc - s0 < 64 && k < 3000)
		begin
			@(posedge ref_clk);
			k++;
		end
		tmo(k, 3000);
		d_sys = c_sys - s1;
		d_per = c_per - s2;
		d_pre = c_pre - s3;
	endtask
	task ratios;
		int e;
		e = 64 / ((m_sys[2:0] == 3'h0) ? 1 : 1 << (int'(m_sys[2:0]) - 3));
		`CHK(inr(d_sys, e - 1, e + 1), 1'b1)
		e = m_sys[12] ? 64 : e;
		`CHK(inr(d_per, e - 1, e + 1), 1'b1)
		e = e >> m_sys[10:8];
		`CHK(inr(d_pre, e - 1, e + 1), 1'b1)
	endtask

	initial
	begin
		rst_n = 1'b0;
		avm_address = 5'h0;
		avm_read = 1'b0;
		avm_write = 1'b0;
		avm_writedata = 32'h0;
		avm_byteenable = 4'h0;
		lp_wake = 1'b0;
		lfsr_q = 32'hc2b660e9;
		m_sys = 32'h0;
		m_osc = 32'h80010030;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		`CHK({int_osc_enable, ext_hs_osc_en, ext_in_en, ls_osc_en, pll_en}, 5'h10)
		rchk(csw_pkg::OFS_SYS_CTRL, 32'h0);
		rchk(csw_pkg::OFS_OSC_CTRL, osc_exp(1'b0));
		rchk(csw_pkg::OFS_EXT_SEL, csw_pkg::EXT_SEL_FIXED);
		rchk(csw_pkg::OFS_SYS_SEL, 32'h0);
		bus(1'b1, 5'h08, 32'hffffffff, 4'hf);
		rchk(5'h08, 32'h0);
		rchk(5'h14, 32'h0);
		meas();
		ratios();
		// Every gear code once, then random words; source chosen first, no core tick timer here
		for (i = 0; i < 16; i++)
		begin
			lfsr_q = lfsr_next(lfsr_q);
			if (i < 8)
				wsys({lfsr_q[31:3], 3'(i)}, 4'hf);
			else
				wsys(lfsr_q, lfsr_q[19:16]);
			rchk(csw_pkg::OFS_SYS_CTRL, m_sys);
			repeat (int'(csw_pkg::GEAR_APPLY_CYC) + 2) @(posedge ref_clk);
			meas();
			ratios();
		end
		wsys(32'h0, 4'hf);
		// High-speed warm-up: lower field ignored, target 16 edges
		wosc(32'h0011c030);
		rchk(csw_pkg::OFS_OSC_CTRL, osc_exp(1'b0));
		wosc(32'h0011c031);
		s = c_fc;
		rchk(csw_pkg::OFS_OSC_CTRL, osc_exp(1'b1));
		poll(csw_pkg::OFS_OSC_CTRL, 32'h2, 32'h0);
		`CHK(inr(c_fc - s, 15, 18), 1'b1)
		// Wake only once the count is over
		s = c_fc;
		@(posedge ref_clk);
		lp_wake <= 1'b1;
		@(posedge ref_clk);
		lp_wake <= 1'b0;
		@(posedge ref_clk);
		`CHK(cpu_clk_hold, 1'b1)
		n = 0;
		while (cpu_clk_hold !== 1'b0 && n < 2000)
		begin
			@(posedge ref_clk);
			n++;
		end
		tmo(n, 2000);
		`CHK(inr(c_fc - s, 15, 19), 1'b1)
		`CHK(hold_bad, 0)
		// Low-speed warm-up uses both fields: 16 + 12 edges
		s = c_ls;
		wosc(32'h0011c239);
		poll(csw_pkg::OFS_OSC_CTRL, 32'h2, 32'h0);
		`CHK(inr(c_ls - s, 26, 30), 1'b1)
		wosc(32'h0011c230);
		bus(1'b1, csw_pkg::OFS_SYS_SEL, 32'h2, 4'hf);
		poll(csw_pkg::OFS_SYS_SEL, 32'h1, 32'h1);
		rchk(csw_pkg::OFS_SYS_SEL, 32'h3);
		meas();
		`CHK(inr(d_sys, 10, 13), 1'b1)
		bus(1'b1, csw_pkg::OFS_OSC_CTRL, 32'h0011c630, 4'hf);
		rchk(csw_pkg::OFS_OSC_CTRL, osc_exp(1'b0));
		bus(1'b1, csw_pkg::OFS_SYS_SEL, 32'h0, 4'hf);
		poll(csw_pkg::OFS_SYS_SEL, 32'h1, 32'h0);
		// Crystal selected: switch to the input pin is refused
		wosc(32'h0013c330);
		// Enable settles only after the write edge
		@(posedge ref_clk);
		`CHK(ext_hs_osc_en, 1'b1)
		// Crystal as warm-up source, lower field ignored
		s = c_fc;
		wosc(32'h001bc331);
		poll(csw_pkg::OFS_OSC_CTRL, 32'h2, 32'h0);
		`CHK(inr(c_fc - s, 15, 19), 1'b1)
		bus(1'b1, csw_pkg::OFS_EXT_SEL, 32'h1, 4'hf);
		rchk(csw_pkg::OFS_EXT_SEL, csw_pkg::EXT_SEL_FIXED);
		wosc(32'h0011cb30);
		bus(1'b1, csw_pkg::OFS_EXT_SEL, 32'h1, 4'hf);
		rchk(csw_pkg::OFS_EXT_SEL, csw_pkg::EXT_SEL_FIXED | 32'h1);
		`CHK(ext_in_en, 1'b1)
		// Clock input pin now feeds the whole tree
		meas();
		ratios();
		stop_test();
	end
endmodule
